// ### modbus_slave_pkg.sv
package modbus_slave_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CHAR_TIME_NS = 1000;
  localparam int CHAR_CYCLES = CHAR_TIME_NS / CLK_PERIOD_NS;
  // Three and a half character times, rounded up to whole cycles
  localparam int GAP_NS = CHAR_TIME_NS * 7 / 2;
  localparam int GAP_CYCLES = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSP_TIMEOUT_NS = 20000;
  localparam int RSP_TIMEOUT_CYCLES = RSP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h06;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [3:0] REQ_BYTES = 4'h8;
  localparam logic [5:0] WRITE_RSP_BYTES = 6'h08;
  localparam logic [15:0] MAX_READ_WORDS = 16'h0010;
  localparam int PARAM_WORDS = 256;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;

  function automatic logic [15:0] crc16_update(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic addr_valid(input logic [7:0] addr);
    return (addr >= ADDR_MIN) && (addr <= ADDR_MAX);
  endfunction
endpackage

// ### modbus_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface modbus_link_if;
  logic [7:0] req_byte;
  logic req_strobe;
  logic [7:0] rsp_byte;
  logic rsp_strobe;
  modport master (output req_byte, output req_strobe, input rsp_byte, input rsp_strobe);
  modport slave (input req_byte, input req_strobe, output rsp_byte, output rsp_strobe);
endinterface
`default_nettype wire

// ### byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,           // System clock
  input wire logic rst_n_in,             // Sync reset, active low
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  input wire logic in_valid_in,          // Write request
  output logic in_ready_out,             // Room for a word
  output logic [WIDTH-1:0] out_data_out, // Head word
  output logic out_valid_out,            // Head word present
  input wire logic out_ready_in          // Pop head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW + 1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW + 1)'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
      in_ready_out <= count_next != (AW + 1)'(DEPTH);
      out_valid_out <= count_next != '0;
    end
  end
endmodule
`default_nettype wire

// ### modbus_param_slave.sv
// Summary of operation
// - Frames bounded by 3.5 character idle gaps
// - Axis address valid only from 1 to 247
// - Response starts with own address, command
// - Byte after command is parameter group number
// - Next byte is offset within group
// - Write value follows, high byte first
// - CRC low byte, then high byte, then gap
// - Write stores value and echoes request
// - Master never writes 32-bit parameter with 0x06
// - Two-word read answers count four, four bytes
// - Master reads 32-bit parameter as two words
// - 32-bit value returned low word first
// - Read request carries start address, word count
// - Read byte count is twice word count
`timescale 1ns/1ps
`default_nettype none
module modbus_param_slave (
  input wire logic ref_clk_in,               // System clock, 10 MHz
  input wire logic rst_n_in,                 // Sync reset, active low
  modbus_link_if.slave link,                 // Byte link to the master
  input wire logic [7:0] own_addr_in,        // This drive's axis address
  input wire logic param_load_in,            // Local parameter load
  input wire logic [7:0] param_load_idx_in,  // Local load word index
  input wire logic [15:0] param_load_data_in, // Local load value
  output logic param_wr_strobe_out,          // Bus write done, pulse
  output logic [15:0] param_wr_addr_out,     // Group and offset written
  output logic [15:0] param_wr_data_out,     // Value written
  output logic responding_out,               // Response in progress
  output logic discard_out                   // Frame dropped, pulse
);
  typedef enum logic {LISTEN_ST, SEND_ST} slave_state_type;

  slave_state_type state_reg;
  logic [15:0] param_mem [0:modbus_slave_pkg::PARAM_WORDS-1];
  logic [7:0] rx_buf [0:7];
  logic [3:0] rx_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] char_cnt_reg;
  logic char_en_reg;
  logic [15:0] idle_cnt_reg;
  logic [5:0] tx_idx_reg;
  logic [5:0] rsp_len_reg;
  logic [15:0] tx_crc_reg;
  logic [7:0] tx_byte_reg;
  logic tx_strobe_reg;
  logic frame_end;
  logic read_ok;
  logic accept;
  logic [7:0] start_idx;
  logic [15:0] word_cnt;
  logic [5:0] payload_len;
  logic [7:0] word_idx;
  logic [15:0] rd_word;
  logic [7:0] rsp_byte;

  assign link.rsp_byte = tx_byte_reg;
  assign link.rsp_strobe = tx_strobe_reg;

  // Character rate enable
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      char_cnt_reg <= 16'h0000;
      char_en_reg <= 1'b0;
    end else begin
      char_en_reg <= char_cnt_reg == 16'(modbus_slave_pkg::CHAR_CYCLES - 1);
      if (char_cnt_reg == 16'(modbus_slave_pkg::CHAR_CYCLES - 1)) begin
        char_cnt_reg <= 16'h0000;
      end else begin
        char_cnt_reg <= char_cnt_reg + 16'h0001;
      end
    end
  end

  // Silence on the line in either direction
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_cnt_reg <= 16'h0000;
    end else if (link.req_strobe || tx_strobe_reg) begin
      idle_cnt_reg <= 16'h0000;
    end else if (idle_cnt_reg != 16'(modbus_slave_pkg::GAP_CYCLES)) begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end

  // Frame closes once the gap has fully elapsed
  assign frame_end = (state_reg == LISTEN_ST) && (rx_cnt_reg != 4'h0) && !link.req_strobe &&
                     (idle_cnt_reg == 16'(modbus_slave_pkg::GAP_CYCLES - 1));

  // Only the first eight bytes are kept; longer frames count up and get dropped
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rx_cnt_reg <= 4'h0;
      rx_crc_reg <= modbus_slave_pkg::CRC_INIT;
    end else if (frame_end) begin
      rx_cnt_reg <= 4'h0;
      rx_crc_reg <= modbus_slave_pkg::CRC_INIT;
    end else if (state_reg == LISTEN_ST && link.req_strobe) begin
      if (rx_cnt_reg != 4'hF) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      rx_crc_reg <= modbus_slave_pkg::crc16_update(rx_crc_reg, link.req_byte);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (state_reg == LISTEN_ST && link.req_strobe && !rx_cnt_reg[3]) begin
      rx_buf[rx_cnt_reg[2:0]] <= link.req_byte;
    end
  end

  // Group byte high, offset low; the index keeps four bits of each
  assign start_idx = {rx_buf[2][3:0], rx_buf[3][3:0]};
  assign word_cnt = {rx_buf[4], rx_buf[5]};
  assign read_ok = (rx_buf[1] == modbus_slave_pkg::CMD_READ) && (word_cnt != 16'h0000) &&
                   (word_cnt <= modbus_slave_pkg::MAX_READ_WORDS);
  // Residue of zero means the appended check bytes matched
  assign accept = (rx_cnt_reg == modbus_slave_pkg::REQ_BYTES) && (rx_crc_reg == 16'h0000) &&
                  modbus_slave_pkg::addr_valid(own_addr_in) && (rx_buf[0] == own_addr_in) &&
                  (read_ok || rx_buf[1] == modbus_slave_pkg::CMD_WRITE);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      discard_out <= 1'b0;
    end else begin
      discard_out <= frame_end && !accept;
    end
  end

  // Local load goes last so it wins a same-cycle collision
  always_ff @(posedge ref_clk_in) begin
    if (frame_end && accept && rx_buf[1] == modbus_slave_pkg::CMD_WRITE) begin
      param_mem[start_idx] <= {rx_buf[4], rx_buf[5]};
    end
    if (param_load_in) begin
      param_mem[param_load_idx_in] <= param_load_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      param_wr_strobe_out <= 1'b0;
      param_wr_addr_out <= 16'h0000;
      param_wr_data_out <= 16'h0000;
    end else begin
      param_wr_strobe_out <= frame_end && accept && rx_buf[1] == modbus_slave_pkg::CMD_WRITE;
      if (frame_end && accept && rx_buf[1] == modbus_slave_pkg::CMD_WRITE) begin
        param_wr_addr_out <= {rx_buf[2], rx_buf[3]};
        param_wr_data_out <= {rx_buf[4], rx_buf[5]};
      end
    end
  end

  // Response byte for the current transmit index
  assign payload_len = rsp_len_reg - 6'h02;
  assign word_idx = start_idx + {3'b000, 5'((tx_idx_reg - 6'h03) >> 1)};
  assign rd_word = param_mem[word_idx];

  always_comb begin
    rsp_byte = 8'h00;
    if (tx_idx_reg == payload_len) begin
      rsp_byte = tx_crc_reg[7:0];
    end else if (tx_idx_reg == payload_len + 6'h01) begin
      rsp_byte = tx_crc_reg[15:8];
    end else if (rx_buf[1] == modbus_slave_pkg::CMD_WRITE) begin
      rsp_byte = rx_buf[tx_idx_reg[2:0]];
    end else begin
      case (tx_idx_reg)
        6'h00: rsp_byte = rx_buf[0];
        6'h01: rsp_byte = rx_buf[1];
        6'h02: rsp_byte = {rx_buf[5][6:0], 1'b0};
        // Stored low word sits at the lower index, so it goes out first
        default: rsp_byte = tx_idx_reg[0] ? rd_word[15:8] : rd_word[7:0];
      endcase
    end
  end

  // Request end already waited a full gap, so the answer may start at once
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= LISTEN_ST;
      tx_idx_reg <= 6'h00;
      rsp_len_reg <= modbus_slave_pkg::WRITE_RSP_BYTES;
      tx_crc_reg <= modbus_slave_pkg::CRC_INIT;
      tx_byte_reg <= 8'h00;
      tx_strobe_reg <= 1'b0;
      responding_out <= 1'b0;
    end else begin
      tx_strobe_reg <= 1'b0;
      case (state_reg)
        LISTEN_ST: begin
          if (frame_end && accept) begin
            state_reg <= SEND_ST;
            responding_out <= 1'b1;
            tx_idx_reg <= 6'h00;
            tx_crc_reg <= modbus_slave_pkg::CRC_INIT;
            if (rx_buf[1] == modbus_slave_pkg::CMD_READ) begin
              rsp_len_reg <= 6'h05 + {rx_buf[5][4:0], 1'b0};
            end else begin
              rsp_len_reg <= modbus_slave_pkg::WRITE_RSP_BYTES;
            end
          end
        end
        SEND_ST: begin
          if (char_en_reg) begin
            tx_byte_reg <= rsp_byte;
            tx_strobe_reg <= 1'b1;
            tx_idx_reg <= tx_idx_reg + 6'h01;
            if (tx_idx_reg < payload_len) begin
              tx_crc_reg <= modbus_slave_pkg::crc16_update(tx_crc_reg, rsp_byte);
            end
            if (tx_idx_reg == rsp_len_reg - 6'h01) begin
              state_reg <= LISTEN_ST;
              responding_out <= 1'b0;
            end
          end
        end
        default: state_reg <= LISTEN_ST;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### modbus_param_master.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_param_master (
  input wire logic ref_clk_in,        // System clock, 10 MHz
  input wire logic rst_n_in,          // Sync reset, active low
  modbus_link_if.master link,         // Byte link to the drive
  input wire logic [7:0] req_data_in, // Request byte, address first, no CRC
  input wire logic req_last_in,       // Marks last byte of the request
  input wire logic req_valid_in,      // Request byte offered
  output logic req_ready_out,         // Queue accepts a byte
  output logic [7:0] rsp_byte_out,    // Received response byte
  output logic rsp_valid_out,         // Response byte pulse
  output logic rsp_done_out,          // Response frame closed, pulse
  output logic rsp_crc_ok_out,        // Response check matched
  output logic rsp_timeout_out,       // No response, pulse
  output logic addr_reject_out,       // Request with bad address dropped
  output logic busy_out               // Transaction under way
);
  typedef enum logic [2:0] {IDLE_ST, SEND_ST, DROP_ST, CRC_LO_ST, CRC_HI_ST, WAIT_ST}
    master_state_type;

  master_state_type state_reg;
  logic [modbus_slave_pkg::FIFO_WIDTH-1:0] fifo_word;
  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] char_cnt_reg;
  logic char_en_reg;
  logic [15:0] idle_cnt_reg;
  logic [15:0] wait_cnt_reg;
  logic [15:0] tx_crc_reg;
  logic [15:0] rx_crc_reg;
  logic [5:0] rx_cnt_reg;
  logic [7:0] tx_byte_reg;
  logic tx_strobe_reg;
  logic gap_ok;

  byte_fifo #(
    .WIDTH(modbus_slave_pkg::FIFO_WIDTH),
    .DEPTH(modbus_slave_pkg::FIFO_DEPTH)
  ) req_queue (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in({req_last_in, req_data_in}),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .out_data_out(fifo_word),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  assign link.req_byte = tx_byte_reg;
  assign link.req_strobe = tx_strobe_reg;
  assign gap_ok = idle_cnt_reg == 16'(modbus_slave_pkg::GAP_CYCLES);
  // Drain at character rate; a bad-address frame drains without pacing
  assign fifo_pop = fifo_valid && ((state_reg == DROP_ST) ||
                    (char_en_reg && state_reg == SEND_ST) ||
                    (char_en_reg && state_reg == IDLE_ST && gap_ok));

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      char_cnt_reg <= 16'h0000;
      char_en_reg <= 1'b0;
    end else begin
      char_en_reg <= char_cnt_reg == 16'(modbus_slave_pkg::CHAR_CYCLES - 1);
      if (char_cnt_reg == 16'(modbus_slave_pkg::CHAR_CYCLES - 1)) begin
        char_cnt_reg <= 16'h0000;
      end else begin
        char_cnt_reg <= char_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_cnt_reg <= 16'h0000;
    end else if (link.rsp_strobe || tx_strobe_reg) begin
      idle_cnt_reg <= 16'h0000;
    end else if (!gap_ok) begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= IDLE_ST;
      tx_byte_reg <= 8'h00;
      tx_strobe_reg <= 1'b0;
      tx_crc_reg <= modbus_slave_pkg::CRC_INIT;
      rx_crc_reg <= modbus_slave_pkg::CRC_INIT;
      rx_cnt_reg <= 6'h00;
      wait_cnt_reg <= 16'h0000;
      rsp_byte_out <= 8'h00;
      rsp_valid_out <= 1'b0;
      rsp_done_out <= 1'b0;
      rsp_crc_ok_out <= 1'b0;
      rsp_timeout_out <= 1'b0;
      addr_reject_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      tx_strobe_reg <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_done_out <= 1'b0;
      rsp_timeout_out <= 1'b0;
      addr_reject_out <= 1'b0;
      busy_out <= state_reg != IDLE_ST;
      case (state_reg)
        IDLE_ST: begin
          if (fifo_pop) begin
            if (!modbus_slave_pkg::addr_valid(fifo_word[7:0])) begin
              addr_reject_out <= 1'b1;
              state_reg <= fifo_word[8] ? IDLE_ST : DROP_ST;
            end else begin
              tx_byte_reg <= fifo_word[7:0];
              tx_strobe_reg <= 1'b1;
              tx_crc_reg <= modbus_slave_pkg::crc16_update(modbus_slave_pkg::CRC_INIT,
                                                           fifo_word[7:0]);
              state_reg <= fifo_word[8] ? CRC_LO_ST : SEND_ST;
            end
          end
        end
        SEND_ST: begin
          if (fifo_pop) begin
            tx_byte_reg <= fifo_word[7:0];
            tx_strobe_reg <= 1'b1;
            tx_crc_reg <= modbus_slave_pkg::crc16_update(tx_crc_reg, fifo_word[7:0]);
            if (fifo_word[8]) begin
              state_reg <= CRC_LO_ST;
            end
          end
        end
        DROP_ST: begin
          if (fifo_pop && fifo_word[8]) begin
            state_reg <= IDLE_ST;
          end
        end
        CRC_LO_ST: begin
          if (char_en_reg) begin
            tx_byte_reg <= tx_crc_reg[7:0];
            tx_strobe_reg <= 1'b1;
            state_reg <= CRC_HI_ST;
          end
        end
        CRC_HI_ST: begin
          if (char_en_reg) begin
            tx_byte_reg <= tx_crc_reg[15:8];
            tx_strobe_reg <= 1'b1;
            rx_crc_reg <= modbus_slave_pkg::CRC_INIT;
            rx_cnt_reg <= 6'h00;
            wait_cnt_reg <= 16'h0000;
            state_reg <= WAIT_ST;
          end
        end
        WAIT_ST: begin
          wait_cnt_reg <= wait_cnt_reg + 16'h0001;
          if (link.rsp_strobe) begin
            rsp_byte_out <= link.rsp_byte;
            rsp_valid_out <= 1'b1;
            rx_crc_reg <= modbus_slave_pkg::crc16_update(rx_crc_reg, link.rsp_byte);
            if (rx_cnt_reg != 6'h3F) begin
              rx_cnt_reg <= rx_cnt_reg + 6'h01;
            end
          end else if (rx_cnt_reg != 6'h00 &&
                       idle_cnt_reg == 16'(modbus_slave_pkg::GAP_CYCLES - 1)) begin
            rsp_done_out <= 1'b1;
            rsp_crc_ok_out <= rx_crc_reg == 16'h0000;
            state_reg <= IDLE_ST;
          end else if (rx_cnt_reg == 6'h00 &&
                       wait_cnt_reg == 16'(modbus_slave_pkg::RSP_TIMEOUT_CYCLES)) begin
            // Slave stays silent on frames it discards
            rsp_timeout_out <= 1'b1;
            state_reg <= IDLE_ST;
          end
        end
        default: state_reg <= IDLE_ST;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### modbus_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_link_properties (
  input wire logic ref_clk_in, // System clock
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic [7:0] req_byte, // Master to drive byte
  input wire logic req_strobe, // Master byte pulse
  input wire logic [7:0] rsp_byte, // Drive to master byte
  input wire logic rsp_strobe // Drive byte pulse
);
  logic [7:0] idle_reg;
  logic last_req_reg;
  logic [7:0] req_idx_reg;
  logic [7:0] rsp_idx_reg;
  logic [7:0] req_reg [0:7];
  logic [7:0] req_pos;
  logic [7:0] rsp_pos;
  // Silence above two char times opens a new frame
  assign req_pos = (idle_reg > 8'h14) ? 8'h00 : req_idx_reg;
  assign rsp_pos = (idle_reg > 8'h14) ? 8'h00 : rsp_idx_reg;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_reg <= 8'hFF;
      last_req_reg <= 1'b0;
      req_idx_reg <= 8'h00;
      rsp_idx_reg <= 8'h00;
    end else begin
      idle_reg <= (req_strobe || rsp_strobe) ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hFF};
      if (req_strobe || rsp_strobe) last_req_reg <= req_strobe;
      if (req_strobe) req_idx_reg <= req_pos + 8'h01;
      if (rsp_strobe) rsp_idx_reg <= rsp_pos + 8'h01;
      // Bytes past the eighth are dropped; longer frames never earn a reply
      if (req_strobe && req_pos < 8'h08) req_reg[req_pos[2:0]] <= req_byte;
    end
  end
  a_req_spacing: assert property (req_strobe |=> !req_strobe [*8] ##1 !req_strobe)
    else $error("request bytes closer than one char time");
  a_rsp_gap: assert property (rsp_strobe && last_req_reg |-> idle_reg inside {[8'h23:8'h30]})
    else $error("reply start outside its window after the gap");
  a_req_gap: assert property (req_strobe && !last_req_reg |-> idle_reg >= 8'h23)
    else $error("request starts without an idle gap");
  a_req_addr: assert property (req_strobe && req_pos == 8'h00 |-> req_byte inside {[8'h01:8'hF7]})
    else $error("request sent with bad axis address");
  a_rsp_head: assert property (rsp_strobe && rsp_pos < 8'h02 |-> rsp_byte == req_reg[rsp_pos[2:0]])
    else $error("reply address or command differs from request");
  a_write_echo: assert property (rsp_strobe && req_reg[1] == 8'h06 && rsp_pos inside {[8'h02:8'h05]}
    |-> rsp_byte == req_reg[rsp_pos[2:0]])
    else $error("write reply does not echo the request");
  a_read_count: assert property (rsp_strobe && req_reg[1] == 8'h03 && rsp_pos == 8'h02
    |-> rsp_byte == {req_reg[5][6:0], 1'b0})
    else $error("read reply byte count wrong");
  a_full_frame: assert property (rsp_strobe && last_req_reg |-> req_idx_reg == 8'h08)
    else $error("reply to a frame that was not eight bytes");
  c_write_reply: cover property (rsp_strobe && rsp_pos == 8'h07 && req_reg[1] == 8'h06);
  c_read_reply: cover property (rsp_strobe && rsp_pos == 8'h02 && req_reg[1] == 8'h03);
  c_long_frame: cover property (req_strobe && req_pos == 8'h08);
endmodule
`default_nettype wire

// ### modbus_parameter_access_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_parameter_access_slave_bench;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] req_data_in = 8'h00;
  logic req_last_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic param_load_in = 1'b0;
  logic [7:0] param_load_idx_in = 8'h00;
  logic [15:0] param_load_data_in = 16'h0000;
  logic req_ready_out, rsp_valid_out, rsp_done_out, rsp_crc_ok_out, rsp_timeout_out;
  logic addr_reject_out, busy_out, param_wr_strobe_out, responding_out, discard_out, discard_b;
  logic [7:0] rsp_byte_out;
  logic [15:0] param_wr_addr_out, param_wr_data_out;
  logic s_done, s_tmo, s_rej, s_disc, s_wr, s_full, s_brsp, s_busy, s_resp;
  logic [7:0] got[$];
  logic [23:0] load_tab [2] = '{24'h57_1234, 24'h58_ABCD};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  modbus_link_if link();
  modbus_link_if link_b();
  modbus_param_master u_modbus_param_master (.ref_clk_in, .rst_n_in, .link(link.master),
    .req_data_in, .req_last_in, .req_valid_in, .req_ready_out, .rsp_byte_out, .rsp_valid_out,
    .rsp_done_out, .rsp_crc_ok_out, .rsp_timeout_out, .addr_reject_out, .busy_out);
  modbus_param_slave u_modbus_param_slave (.ref_clk_in, .rst_n_in, .link(link.slave),
    .own_addr_in(8'h01), .param_load_in, .param_load_idx_in, .param_load_data_in,
    .param_wr_strobe_out, .param_wr_addr_out, .param_wr_data_out, .responding_out, .discard_out);
  // Second drive fed by hand, for a bad-check frame the master never builds and its good twin
  modbus_param_slave u_modbus_param_slave_b (.ref_clk_in, .rst_n_in, .link(link_b.slave),
    .own_addr_in(8'h01), .param_load_in, .param_load_idx_in,
    .param_load_data_in, .param_wr_strobe_out(), .param_wr_addr_out(),
    .param_wr_data_out(), .responding_out(), .discard_out(discard_b));
  modbus_link_properties u_modbus_link_properties (.ref_clk_in, .rst_n_in,
    .req_byte(link.req_byte), .req_strobe(link.req_strobe), .rsp_byte(link.rsp_byte),
    .rsp_strobe(link.rsp_strobe));
  initial forever #50 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) begin
    if (rsp_valid_out) got.push_back(rsp_byte_out);
    if (rsp_done_out) s_done = 1'b1;
    if (rsp_timeout_out) s_tmo = 1'b1;
    if (addr_reject_out) s_rej = 1'b1;
    if (discard_out || discard_b) s_disc = 1'b1;
    if (param_wr_strobe_out) s_wr = 1'b1;
    if (req_valid_in && !req_ready_out) s_full = 1'b1;
    if (link_b.rsp_strobe) s_brsp = 1'b1;
    if (busy_out) s_busy = 1'b1;
    if (responding_out) s_resp = 1'b1;
  end
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR %0t: run did not finish", $time);
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic bad, input string msg);
    n_checks++;
    if (bad) begin
      n_fail++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic push(input logic [7:0] q[$]);
    foreach (q[i]) begin
      req_data_in = q[i];
      req_last_in = (i == q.size() - 1);
      req_valid_in = 1'b1;
      while (!req_ready_out) @(negedge ref_clk_in);
      @(negedge ref_clk_in);
    end
    req_valid_in = 1'b0;
    req_last_in = 1'b0;
  endtask
  // Request is six payload bytes plus pad filler; reply given without check bytes
  task automatic xact(input logic [47:0] req, input logic [63:0] rsp, input int rn,
                      input int pad, input logic disc, input logic rej);
    logic [7:0] q[$];
    logic [7:0] exp[$];
    logic [15:0] c;
    int n;
    for (int i = 0; i < 6; i++) q.push_back(req[(5 - i) * 8 +: 8]);
    repeat (pad) q.push_back(8'h03);
    for (int i = 0; i < rn; i++) exp.push_back(rsp[(rn - 1 - i) * 8 +: 8]);
    if (rn > 0) begin
      c = crc_of(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    got.delete();
    {s_done, s_tmo, s_rej, s_disc, s_wr, s_full, s_busy, s_resp} = 8'h00;
    push(q);
    n = 0;
    while (!(s_done || s_tmo || s_rej) && n < 1500) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(got.size() != exp.size(), "reply length");
    foreach (exp[i]) if (i < got.size()) check(got[i] !== exp[i], "reply byte");
    check(s_done !== (rn > 0), "reply frame end");
    if (rn > 0) check(rsp_crc_ok_out !== 1'b1, "reply check bytes");
    check(s_disc !== disc, "frame discard");
    check(s_rej !== rej, "address reject");
    check(s_resp !== (rn > 0), "drive responding");
    repeat (40) @(negedge ref_clk_in);
    check(s_busy !== 1'b1 || busy_out !== 1'b0, "master busy");
  endtask
  task automatic drive_b(input logic [7:0] flip, input logic answered);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {8'h01, 8'h06, 8'h00, 8'h11, 8'h12, 8'h34};
    c = crc_of(q);
    q.push_back(c[7:0] ^ flip);
    q.push_back(c[15:8]);
    {s_brsp, s_disc} = 2'h0;
    foreach (q[i]) begin
      link_b.req_byte = q[i];
      link_b.req_strobe = 1'b1;
      @(negedge ref_clk_in);
      link_b.req_strobe = 1'b0;
      // Inverted once released, so a stale byte never passes for data
      link_b.req_byte = ~q[i];
      repeat (9) @(negedge ref_clk_in);
    end
    repeat (200) @(negedge ref_clk_in);
    check(s_brsp !== answered, "hand frame reply");
    check(s_disc === answered, "hand frame discard");
  endtask
  initial begin
    link_b.req_byte = 8'h00;
    link_b.req_strobe = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    @(negedge ref_clk_in);
    for (int i = 0; i < 2; i++) begin
      {param_load_idx_in, param_load_data_in} = load_tab[i];
      param_load_in = 1'b1;
      @(negedge ref_clk_in);
    end
    param_load_in = 1'b0;
    xact(48'h0106_0202_0001, 64'h0000_0106_0202_0001, 6, 0, 1'b0, 1'b0);
    check(s_wr !== 1'b1 || param_wr_addr_out !== 16'h0202 || param_wr_data_out !== 16'h0001,
      "stored write");
    xact(48'h0103_0202_0001, 64'h0000_0001_0302_0001, 5, 0, 1'b0, 1'b0);
    xact(48'h0103_0507_0002, 64'h0001_0304_1234_ABCD, 7, 0, 1'b0, 1'b0);
    xact(48'h0106_0F0F_FFFF, 64'h0000_0106_0F0F_FFFF, 6, 0, 1'b0, 1'b0);
    xact(48'h0103_0F0F_0001, 64'h0000_0001_0302_FFFF, 5, 0, 1'b0, 1'b0);
    xact(48'h0206_0202_0005, 64'h0, 0, 0, 1'b1, 1'b0);
    xact(48'hF706_0202_0005, 64'h0, 0, 0, 1'b1, 1'b0);
    xact(48'h0006_0202_0005, 64'h0, 0, 0, 1'b0, 1'b1);
    xact(48'hF806_0202_0005, 64'h0, 0, 0, 1'b0, 1'b1);
    xact(48'h0103_0202_0000, 64'h0, 0, 0, 1'b1, 1'b0);
    xact(48'h0103_0202_0011, 64'h0, 0, 0, 1'b1, 1'b0);
    xact(48'h0110_0202_0005, 64'h0, 0, 0, 1'b1, 1'b0);
    xact(48'h0103_0202_0001, 64'h0, 0, 34, 1'b1, 1'b0);
    check(s_full !== 1'b1, "request queue never filled");
    drive_b(8'h00, 1'b1);
    drive_b(8'h01, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
